/* hw/dctt_pkg.sv */
// Purpose: Shared constants and state types for the dual time-base timers
// Assumes: 16-bit register port, byte-wide identical timer control fields
// Notes:   Timer index 0 is timer_a (low byte), index 1 is timer_b
package dctt_pkg;

    // Widths and counts
    localparam int DCTT_NUM_TIMERS = 2;
    localparam int DCTT_DATA_W = 16;
    localparam int DCTT_ADDR_W = 16;
    localparam int DCTT_PRE_W = 10;

    // Register addresses
    localparam logic [15:0] DCTT_OFS_CTRL = 16'hFF20;
    localparam logic [15:0] DCTT_OFS_CNT_A = 16'hFF24;
    localparam logic [15:0] DCTT_OFS_CNT_B = 16'hFF28;
    localparam logic [15:0] DCTT_OFS_REL_A = 16'hFF2C;
    localparam logic [15:0] DCTT_OFS_REL_B = 16'hFF30;
    localparam logic [15:0] DCTT_OFS_FLAG = 16'hFF34;

    // Field positions inside one control byte
    localparam int DCTT_BYTE_W = 8;
    localparam int DCTT_RUN_BIT = 6;
    localparam int DCTT_RSEL_LSB = 4;
    localparam int DCTT_MODE_BIT = 3;
    localparam int DCTT_SEL_LSB = 0;

    // Reset values and masks
    localparam logic [15:0] DCTT_CTRL_RESET = 16'h0000;
    localparam logic [15:0] DCTT_CTRL_WMASK = 16'h7F7F;
    localparam logic [15:0] DCTT_CNT_RESET = 16'h0000;
    localparam logic [15:0] DCTT_REL_RESET = 16'h0000;
    localparam logic [15:0] DCTT_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] DCTT_CNT_STEP = 16'h0001;
    localparam logic [9:0] DCTT_PRE_RESET = 10'h000;
    localparam logic [9:0] DCTT_PRE_ONE = 10'h001;
    localparam logic [3:0] DCTT_STAGGER_EXTRA = 4'h3;

    // Counter mode event sources
    localparam logic [2:0] DCTT_SRC_NEIGH = 3'h0;
    localparam logic [2:0] DCTT_SRC_RISE = 3'h1;
    localparam logic [2:0] DCTT_SRC_FALL = 3'h2;
    localparam logic [2:0] DCTT_SRC_ANY = 3'h3;

    // Hardware run select codes
    localparam logic [1:0] DCTT_RSEL_OFF = 2'h0;
    localparam logic [1:0] DCTT_RSEL_RISE = 2'h1;
    localparam logic [1:0] DCTT_RSEL_FALL = 2'h2;
    localparam logic [1:0] DCTT_RSEL_ANY = 2'h3;

    // Top-level state
    typedef struct packed {
        logic [15:0] ctrl;
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] rel;
        logic [1:0] flag;
        logic [1:0] ovf;
        logic [15:0] rdata;
    } dctt_state_t;

    localparam dctt_state_t DCTT_STATE_RESET = '{
        ctrl: DCTT_CTRL_RESET,
        cnt: {2{DCTT_CNT_RESET}},
        rel: {2{DCTT_REL_RESET}},
        flag: 2'h0,
        ovf: 2'h0,
        rdata: 16'h0000
    };

    // Prescaler state, with a gap counter watched by assertions
    typedef struct packed {
        logic [9:0] cnt;
        logic [9:0] gap;
        logic [3:0] exp;
    } dctt_pre_state_t;

    // Synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } dctt_sync_state_t;

endpackage : dctt_pkg

/* hw/dctt_sync_edge.sv */
// Purpose: Two-flop synchroniser with rising and falling edge pulses
// Assumes: Input is asynchronous to ref_clk
// Notes:   Edge pulses last one cycle, from the second clock edge after the pin
`timescale 1ns/1ps
module dctt_sync_edge (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pin side
    input wire logic din,
    // Edge pulses
    output logic rise,
    output logic fall
);
    import dctt_pkg::*;

    dctt_sync_state_t st_q;
    dctt_sync_state_t st_d;

    // Shift chain; only s2 reads s1
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Edges seen on the synchronised level
    assign rise = st_q.s2 & ~st_q.s3;
    assign fall = ~st_q.s2 & st_q.s3;

endmodule : dctt_sync_edge

/* hw/dctt_prescale.sv */
// Purpose: Free-running prescaler giving a count tick every 2^k cycles
// Assumes: k = select, plus three in staggered operation
// Notes:   Free running, so first tick after start comes within one period
`timescale 1ns/1ps
module dctt_prescale (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic [2:0] sel,
    input wire logic stagger,
    // Tick out
    output logic tick
);
    import dctt_pkg::*;

    dctt_pre_state_t st_q;
    dctt_pre_state_t st_d;
    logic [3:0] exp_w;
    logic [9:0] mask_w;
    // Gap means nothing until a tick at the current ratio
    localparam logic [3:0] DCTT_EXP_DISARMED = 4'hF;

    // Division exponent and mask of low counter bits
    assign exp_w = {1'b0, sel} + (stagger ? DCTT_STAGGER_EXTRA : 4'h0); // R11 R12
    assign mask_w = (DCTT_PRE_ONE << exp_w) - DCTT_PRE_ONE; // R16
    assign tick = (st_q.cnt & mask_w) == mask_w; // R10

    // Counter and tick gap tracking
    always_comb
    begin
        st_d = st_q;
        st_d.cnt = st_q.cnt + DCTT_PRE_ONE;
        if (tick)
        begin
            st_d.gap = DCTT_PRE_RESET;
            st_d.exp = exp_w;
        end
        else
        begin
            st_d.gap = st_q.gap + DCTT_PRE_ONE;
            // Ratio change: next tick may come early, so disarm
            if (exp_w != st_q.exp)
            begin
                st_d.exp = DCTT_EXP_DISARMED;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_q <= '{cnt: DCTT_PRE_RESET, gap: DCTT_PRE_RESET,
                exp: DCTT_EXP_DISARMED};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Exact spacing while the ratio stays put
    AST_TICK_SPACING: assert property ( // R15
        @(posedge ref_clk) disable iff (!rst_n)
        (tick && exp_w == st_q.exp) |-> (st_q.gap == mask_w))
        else $error("prescaler tick spacing wrong");

endmodule : dctt_prescale

/* hw/dctt_timers.sv */
// Purpose: Two 16-bit up-counting time bases with reload and run control
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes:   Pins pass a two-flop synchroniser; neighbour pulse is on-clock
// Operation
// R01: Timers only ever count upward
// R02: Software count write beats increment or reload
// R03: Upper byte timer_b, lower byte timer_a
// R04: Run bit at 14 and 6, 1 counts
// R05: Mode bit at 11 and 3, 1 counts events
// R06: Input select picks neighbour, rise, fall, any
// R07: timer_b counts only neighbour overflow events
// R08: timer_a hardware run set on chosen edge
// R09: timer_b hardware run set, same encoding
// R10: Each timer has its own prescaler
// R11: Staggered ratio is two to select plus three
// R12: Non-staggered ratio is two to select
// R13: Past maximum, timer loads its reload value
// R14: Period is reload distance times prescaler ratio
// R15: First tick within one interval, then exact
// R16: Finest resolution eight or one cycles
// R17: Overflow sets the timer's request flag
// R18: Reload registers reset to zero
// R19: Staggered input selects eight-step output spreading; stagger_mode only multiplies the prescaler ratio by eight
// R20: Stagger selection arrives as external input
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module dctt_timers (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [dctt_pkg::DCTT_ADDR_W-1:0] reg_addr,
    input wire logic [dctt_pkg::DCTT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dctt_pkg::DCTT_DATA_W-1:0] reg_rdata,
    // Shared configuration
    input wire logic stagger_mode,
    // Pins
    input wire logic count_pin_a,
    input wire logic ext_run_signal_a,
    input wire logic ext_run_signal_b,
    // Neighbour timer overflow or underflow pulse
    input wire logic neighbour_timer_ovf,
    // Timer values and events
    output logic [dctt_pkg::DCTT_DATA_W-1:0] timer_a_count,
    output logic [dctt_pkg::DCTT_DATA_W-1:0] timer_b_count,
    output logic overflow_pulse_a,
    output logic overflow_pulse_b,
    output logic overflow_request_flag_a,
    output logic overflow_request_flag_b
);
    import dctt_pkg::*;

    dctt_state_t st_q;
    dctt_state_t st_d;

    logic [1:0] run;
    logic [1:0] mode;
    logic [1:0][2:0] sel;
    logic [1:0][1:0] rsel;
    logic [1:0] pre_tick;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic [1:0] hr_rise;
    logic [1:0] hr_fall;
    logic [1:0] hw_run_set;
    logic [1:0] count_evt;
    logic [1:0] cnt_inc;
    logic [1:0] cnt_wr;
    logic [1:0] rel_wr;
    logic [1:0] ext_run;
    logic [1:0][15:0] cnt_ofs;
    logic [1:0][15:0] rel_ofs;

    assign ext_run = {ext_run_signal_b, ext_run_signal_a};
    assign cnt_ofs = {DCTT_OFS_CNT_B, DCTT_OFS_CNT_A};
    assign rel_ofs = {DCTT_OFS_REL_B, DCTT_OFS_REL_A};

    // Count pin of timer_a; timer_b has none
    dctt_sync_edge u_pin_a (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din(count_pin_a),
        .rise(pin_rise[0]),
        .fall(pin_fall[0])
    );
    assign pin_rise[1] = 1'b0; // R07
    assign pin_fall[1] = 1'b0; // R07

    // Per-timer field decode, prescaler, run and count qualifiers
    for (genvar g = 0; g < DCTT_NUM_TIMERS; g++)
    begin : g_tmr
        localparam int B = g * DCTT_BYTE_W;

        assign run[g] = st_q.ctrl[B + DCTT_RUN_BIT]; // R03 R04
        assign mode[g] = st_q.ctrl[B + DCTT_MODE_BIT]; // R05
        assign sel[g] = st_q.ctrl[B + DCTT_SEL_LSB +: 3];
        assign rsel[g] = st_q.ctrl[B + DCTT_RSEL_LSB +: 2];

        // Own prescaler per timer, ratio from stagger input
        dctt_prescale u_pre (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .sel(sel[g]),
            .stagger(stagger_mode),
            .tick(pre_tick[g])
        ); // R10 R19 R20

        // Hardware run signal edges
        dctt_sync_edge u_hr (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .din(ext_run[g]),
            .rise(hr_rise[g]),
            .fall(hr_fall[g])
        );

        // Edge chosen by the hardware run select field
        always_comb
        begin
            case (rsel[g])
                DCTT_RSEL_RISE: hw_run_set[g] = hr_rise[g]; // R08 R09
                DCTT_RSEL_FALL: hw_run_set[g] = hr_fall[g]; // R08 R09
                DCTT_RSEL_ANY: hw_run_set[g] = hr_rise[g] | hr_fall[g];
                default: hw_run_set[g] = 1'b0;
            endcase
        end

        // Counter mode event; reserved codes count nothing
        always_comb
        begin
            case (sel[g])
                DCTT_SRC_NEIGH: count_evt[g] = neighbour_timer_ovf; // R06
                DCTT_SRC_RISE: count_evt[g] = pin_rise[g]; // R06
                DCTT_SRC_FALL: count_evt[g] = pin_fall[g]; // R06
                DCTT_SRC_ANY: count_evt[g] = pin_rise[g] | pin_fall[g];
                default: count_evt[g] = 1'b0; // R07
            endcase
        end

        assign cnt_inc[g] = run[g] & (mode[g] ? count_evt[g] : pre_tick[g]);
        assign cnt_wr[g] = reg_wr && (reg_addr == cnt_ofs[g]);
        assign rel_wr[g] = reg_wr && (reg_addr == rel_ofs[g]);
    end

    // Next-state: control, counts, reloads, flags, read data
    always_comb
    begin
        st_d = st_q;
        st_d.ovf = 2'h0;
        st_d.rdata = 16'h0000;
        if (reg_wr && (reg_addr == DCTT_OFS_CTRL))
        begin
            st_d.ctrl = reg_wdata & DCTT_CTRL_WMASK;
        end
        for (int i = 0; i < DCTT_NUM_TIMERS; i++)
        begin
            // Hardware set wins over a software clear
            if (hw_run_set[i])
            begin
                st_d.ctrl[i * DCTT_BYTE_W + DCTT_RUN_BIT] = 1'b1; // R08 R09
            end
            if (cnt_wr[i])
            begin
                st_d.cnt[i] = reg_wdata; // R02
            end
            else if (cnt_inc[i])
            begin
                if (st_q.cnt[i] == DCTT_CNT_MAX)
                begin
                    st_d.cnt[i] = st_q.rel[i]; // R13 R14
                    st_d.ovf[i] = 1'b1;
                end
                else
                begin
                    st_d.cnt[i] = st_q.cnt[i] + DCTT_CNT_STEP; // R01
                end
            end
            if (rel_wr[i])
            begin
                st_d.rel[i] = reg_wdata;
            end
            // Write one clears; a new overflow wins
            if (reg_wr && (reg_addr == DCTT_OFS_FLAG) && reg_wdata[i])
            begin
                st_d.flag[i] = 1'b0;
            end
            if (st_d.ovf[i])
            begin
                st_d.flag[i] = 1'b1; // R17
            end
        end
        if (reg_rd)
        begin
            case (reg_addr)
                DCTT_OFS_CTRL: st_d.rdata = st_q.ctrl;
                DCTT_OFS_CNT_A: st_d.rdata = st_q.cnt[0];
                DCTT_OFS_CNT_B: st_d.rdata = st_q.cnt[1];
                DCTT_OFS_REL_A: st_d.rdata = st_q.rel[0];
                DCTT_OFS_REL_B: st_d.rdata = st_q.rel[1];
                DCTT_OFS_FLAG: st_d.rdata = DCTT_DATA_W'(st_q.flag);
                default: st_d.rdata = 16'h0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_q <= DCTT_STATE_RESET; // R18
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs from flops
    assign reg_rdata = st_q.rdata;
    assign timer_a_count = st_q.cnt[0];
    assign timer_b_count = st_q.cnt[1];
    assign overflow_pulse_a = st_q.ovf[0];
    assign overflow_pulse_b = st_q.ovf[1];
    assign overflow_request_flag_a = st_q.flag[0];
    assign overflow_request_flag_b = st_q.flag[1];

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    AST_A_ONLY_UP: assert property ( // R01
        (!cnt_wr[0] && st_q.cnt[0] != DCTT_CNT_MAX) |=>
        (st_q.cnt[0] == $past(st_q.cnt[0]) ||
         st_q.cnt[0] == $past(st_q.cnt[0]) + DCTT_CNT_STEP))
        else $error("timer_a moved other than up by one");

    AST_WRITE_WINS: assert property ( // R02
        cnt_wr[1] |=> (timer_b_count == $past(reg_wdata)) && !overflow_pulse_b)
        else $error("count write did not take priority");

    AST_STOPPED_HOLDS: assert property ( // R04
        (!run[1] && !cnt_wr[1]) |=> $stable(timer_b_count))
        else $error("stopped timer_b changed");

    AST_B_NEIGH_ONLY: assert property ( // R07
        (mode[1] && sel[1] != DCTT_SRC_NEIGH && !cnt_wr[1])
        |=> $stable(timer_b_count))
        else $error("timer_b counted a non-neighbour source");

    AST_CTRL_READ: assert property ( // R03
        (reg_rd && reg_addr == DCTT_OFS_CTRL) |=>
        (reg_rdata == $past(st_q.ctrl)) && !reg_rdata[15] && !reg_rdata[7])
        else $error("control read back wrong");

    AST_RELOAD: assert property ( // R13
        (cnt_inc[0] && !cnt_wr[0] && st_q.cnt[0] == DCTT_CNT_MAX) |=>
        (timer_a_count == $past(st_q.rel[0])) && overflow_pulse_a)
        else $error("timer_a did not reload at maximum");

    AST_FLAG_SET: assert property ( // R17
        overflow_pulse_a |-> overflow_request_flag_a)
        else $error("overflow did not raise flag");

    AST_HW_RUN_A: assert property ( // R08
        (rsel[0] == DCTT_RSEL_RISE && hr_rise[0]) |=> run[0])
        else $error("hardware run edge did not set run bit");

    AST_FULL_RATE: assert property ( // R12
        (run[0] && !mode[0] && !stagger_mode && sel[0] == DCTT_SRC_NEIGH
         && !cnt_wr[0] && st_q.cnt[0] != DCTT_CNT_MAX)
        |=> timer_a_count == $past(timer_a_count) + DCTT_CNT_STEP)
        else $error("undivided timer missed a cycle");

    AST_STAGGER_MIN: assert property ( // R16
        (cnt_inc[1] && stagger_mode && !mode[1]) |=>
        (!cnt_inc[1] || !stagger_mode || mode[1] || $changed(st_q.ctrl))[*7])
        else $error("staggered timer counted faster than eight cycles");

    AST_REL_RESET: assert property ( // R18
        $rose(rst_n) |-> (st_q.rel[0] == DCTT_REL_RESET &&
        st_q.rel[1] == DCTT_REL_RESET))
        else $error("reload not zero after reset");

    AST_HW_RUN_B: assert property ( // R09
        (rsel[1] == DCTT_RSEL_FALL && hr_fall[1]) |=> run[1])
        else $error("timer_b hardware run edge did not set run bit");

    AST_B_OVF_FLAG: assert property ( // R17
        (cnt_inc[1] && !cnt_wr[1] && st_q.cnt[1] == DCTT_CNT_MAX) |=>
        (overflow_pulse_b && overflow_request_flag_b))
        else $error("timer_b overflow did not raise its flag");

    AST_FLAG_STICKY: assert property ( // R17
        (overflow_request_flag_b && !(reg_wr && reg_addr == DCTT_OFS_FLAG))
        |=> overflow_request_flag_b)
        else $error("timer_b flag dropped without a clear");

    COV_OVF_A: cover property (overflow_pulse_a);
    COV_HW_START: cover property (!run[1] ##1 run[1] && $past(hw_run_set[1]));
    COV_PIN_COUNT: cover property (mode[0] && cnt_inc[0] && pin_fall[0]);
    COV_B_NEIGH: cover property (mode[1] && cnt_inc[1]);

endmodule : dctt_timers

/* tb/tb.sv */
// Purpose: Self-checking bench for the dual time-base timers
// Assumes: One-cycle register strobes, read data in the following cycle
// Notes:   Inputs move by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module tb;
    import dctt_pkg::*;

    // Clock, reset and design inputs
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic stagger_mode = 1'b0;
    logic count_pin_a = 1'b0;
    logic ext_run_signal_a = 1'b0;
    logic ext_run_signal_b = 1'b0;
    logic neighbour_timer_ovf = 1'b0;
    // Design outputs
    logic [15:0] reg_rdata;
    logic [15:0] timer_a_count;
    logic [15:0] timer_b_count;
    logic overflow_pulse_a;
    logic overflow_pulse_b;
    logic overflow_request_flag_a;
    logic overflow_request_flag_b;
    // Score keeping
    int mismatches = 0;
    int compares = 0;

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    // Device under test
    dctt_timers dctt_timers_inst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .stagger_mode(stagger_mode),
        .count_pin_a(count_pin_a),
        .ext_run_signal_a(ext_run_signal_a),
        .ext_run_signal_b(ext_run_signal_b),
        .neighbour_timer_ovf(neighbour_timer_ovf),
        .timer_a_count(timer_a_count),
        .timer_b_count(timer_b_count),
        .overflow_pulse_a(overflow_pulse_a),
        .overflow_pulse_b(overflow_pulse_b),
        .overflow_request_flag_a(overflow_request_flag_a),
        .overflow_request_flag_b(overflow_request_flag_b)
    );

    // Verdict and end of run
    task automatic conclude();
        if (mismatches == 0 && compares > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // A wait that used up its bound
    task automatic give_up();
        mismatches++;
        $display("mismatch at %0t: wait ran out", $time);
        conclude();
    endtask : give_up

    // Compare of a register or count value
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: value %h, want %h", $time, got, exp);
        end
    endtask : chk_val

    // Compare of a measured cycle count
    task automatic chk_int(input int got, input int exp);
        compares++;
        if (got != exp)
        begin
            mismatches++;
            $display("mismatch at %0t: cycles %0d, want %0d", $time, got, exp);
        end
    endtask : chk_int

    // One write cycle on the register port
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One read cycle, data checked in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk_val(reg_rdata, exp);
    endtask : rd

    function automatic logic [15:0] cnt(input logic idx);
        return idx ? timer_b_count : timer_a_count;
    endfunction : cnt

    // Cycles between two increments; the second increment is checked as plus one
    task automatic gap(input logic idx, input int lim, output int n);
        logic [15:0] v;
        int i;
        @(negedge ref_clk);
        v = cnt(idx);
        i = 0;
        while (cnt(idx) === v)
        begin
            if (i > lim) give_up();
            i++;
            @(negedge ref_clk);
        end
        v = cnt(idx);
        n = 0;
        while (cnt(idx) === v)
        begin
            if (n > lim) give_up();
            n++;
            @(negedge ref_clk);
        end
        chk_val(cnt(idx), v + 16'h0001);
    endtask : gap

    // Cycles up to the next overflow pulse of timer_a
    task automatic wait_pulse(output int n);
        n = 1;
        @(negedge ref_clk);
        while (overflow_pulse_a !== 1'b1)
        begin
            if (n > 100) give_up();
            n++;
            @(negedge ref_clk);
        end
    endtask : wait_pulse

    // Moves one hardware run signal, then lets the synchroniser settle
    task automatic set_run(input logic idx, input logic v);
        @(posedge ref_clk);
        if (idx)
            ext_run_signal_b <= v;
        else
            ext_run_signal_a <= v;
        repeat (6) @(posedge ref_clk);
    endtask : set_run

    // Main sequence
    initial
    begin
        int n;
        int s;
        int c;
        int r;
        int k;
        logic [7:0] bv;
        logic [15:0] ctl;
        logic [15:0] run_m;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset values, unmapped place, write mask of control
        rd(DCTT_OFS_CTRL, 16'h0000);
        rd(DCTT_OFS_REL_A, 16'h0000);
        rd(DCTT_OFS_REL_B, 16'h0000);
        rd(DCTT_OFS_CNT_A, 16'h0000);
        rd(DCTT_OFS_CNT_B, 16'h0000);
        rd(DCTT_OFS_FLAG, 16'h0000);
        wr(16'hFF22, 16'hFFFF);
        rd(16'hFF22, 16'h0000);
        rd(DCTT_OFS_CTRL, 16'h0000);
        wr(DCTT_OFS_CTRL, 16'hFFFF);
        rd(DCTT_OFS_CTRL, 16'h7F7F);
        wr(DCTT_OFS_CTRL, 16'h0000);
        // Prescaler ratios, both timers with different selects
        for (s = 0; s < 2; s++)
        begin
            @(posedge ref_clk);
            stagger_mode <= s[0];
            for (c = 0; c < 8; c++)
            begin
                k = 1 << (c + 3 * s);
                ctl = {5'b01000, 3'(c ^ 1), 5'b01000, 3'(c)};
                wr(DCTT_OFS_CTRL, ctl);
                gap(1'b0, k + 2, n);
                chk_int(n, k);
                gap(1'b1, 2 * k + 2, n);
                chk_int(n, 1 << ((c ^ 1) + 3 * s));
            end
        end
        // Stopped timer, reload on overflow and request flag
        @(posedge ref_clk);
        stagger_mode <= 1'b0;
        wr(DCTT_OFS_CTRL, 16'h0000);
        wr(DCTT_OFS_REL_A, 16'hFFF0);
        wr(DCTT_OFS_CNT_A, 16'hFFFD);
        repeat (4) @(posedge ref_clk);
        rd(DCTT_OFS_CNT_A, 16'hFFFD);
        rd(DCTT_OFS_REL_A, 16'hFFF0);
        wr(DCTT_OFS_CTRL, 16'h0040);
        wait_pulse(n);
        chk_val(timer_a_count, 16'hFFF0);
        wait_pulse(n);
        chk_int(n, 16);
        // Count write at an increment edge wins
        wr(DCTT_OFS_CNT_A, 16'h1234);
        @(negedge ref_clk);
        chk_val(timer_a_count, 16'h1234);
        wr(DCTT_OFS_CTRL, 16'h0000);
        rd(DCTT_OFS_FLAG, 16'h0001);
        chk_val({15'h0000, overflow_request_flag_a}, 16'h0001);
        wr(DCTT_OFS_FLAG, 16'h0001);
        rd(DCTT_OFS_FLAG, 16'h0000);
        chk_val({15'h0000, overflow_request_flag_a}, 16'h0000);
        // Timer_b reload, overflow pulse and request flag
        wr(DCTT_OFS_REL_B, 16'hFFFE);
        wr(DCTT_OFS_CNT_B, 16'hFFFF);
        wr(DCTT_OFS_CTRL, 16'h4000);
        @(negedge ref_clk);
        chk_val({15'h0000, overflow_pulse_b}, 16'h0000);
        @(negedge ref_clk);
        chk_val({15'h0000, overflow_pulse_b}, 16'h0001);
        chk_val({15'h0000, overflow_request_flag_b}, 16'h0001);
        chk_val(timer_b_count, 16'hFFFE);
        @(negedge ref_clk);
        chk_val({15'h0000, overflow_pulse_b}, 16'h0000);
        chk_val(timer_b_count, 16'hFFFF);
        wr(DCTT_OFS_CTRL, 16'h0000);
        rd(DCTT_OFS_FLAG, 16'h0002);
        wr(DCTT_OFS_FLAG, 16'h0002);
        rd(DCTT_OFS_FLAG, 16'h0000);
        chk_val({15'h0000, overflow_request_flag_b}, 16'h0000);
        // Counter mode: every input select code on both timers
        for (c = 0; c < 8; c++)
        begin
            bv = {5'b01001, 3'(c)};
            wr(DCTT_OFS_CNT_A, 16'h0000);
            wr(DCTT_OFS_CNT_B, 16'h0000);
            wr(DCTT_OFS_CTRL, {bv, bv});
            repeat (3)
            begin
                @(posedge ref_clk);
                neighbour_timer_ovf <= 1'b1;
                @(posedge ref_clk);
                neighbour_timer_ovf <= 1'b0;
                repeat (2) @(posedge ref_clk);
            end
            repeat (4)
            begin
                @(posedge ref_clk);
                count_pin_a <= ~count_pin_a;
                repeat (6) @(posedge ref_clk);
            end
            wr(DCTT_OFS_CTRL, 16'h0000);
            rd(DCTT_OFS_CNT_A, (c == 0) ? 16'h0003 : (c == 3) ? 16'h0004 :
                (c < 3) ? 16'h0002 : 16'h0000);
            rd(DCTT_OFS_CNT_B, (c == 0) ? 16'h0003 : 16'h0000);
        end
        // Hardware run select codes on both timers
        for (r = 0; r < 8; r++)
        begin
            ctl = r[2] ? {2'b00, r[1:0], 4'hC, 8'h00}
                : {8'h00, 2'b00, r[1:0], 4'hC};
            run_m = r[2] ? 16'h4000 : 16'h0040;
            wr(DCTT_OFS_CTRL, ctl);
            set_run(r[2], 1'b1);
            rd(DCTT_OFS_CTRL, ctl | ((r[1:0] == 2'h1 || r[1:0] == 2'h3)
                ? run_m : 16'h0000));
            set_run(r[2], 1'b0);
            rd(DCTT_OFS_CTRL, ctl | ((r[1:0] != 2'h0)
                ? run_m : 16'h0000));
        end
        wr(DCTT_OFS_CTRL, 16'h0000);
        conclude();
    end

endmodule : tb
